// ===== ieq_map.svh
// Purpose: Constants for the instrument error queue
// Assumes: 200 MHz clock
// Notes:   Codes are 16-bit two's complement
`ifndef IEQ_MAP_SVH
`define IEQ_MAP_SVH
`define IEQ_DEPTH        20
`define IEQ_PTR_W        5
`define IEQ_CODE_W       16
`define IEQ_MSG_W        8
`define IEQ_CODE_NONE    16'h0000
`define IEQ_CODE_OVFL    16'hFEA2
`define IEQ_MSG_NONE     8'h00
`define IEQ_MSG_OVFL     8'h01
`define IEQ_TEXT_MAX     80
`define IEQ_CLK_MHZ      200
`define IEQ_IDLE_S       30
`define IEQ_IDLE_CYC     (64'(`IEQ_IDLE_S) * 64'(`IEQ_CLK_MHZ) * 64'h0000_0000_000F_4240)
`endif

// ===== ieq_pkg.sv
// Purpose: Types for the instrument error queue
// Assumes: ieq_map.svh constants
// Notes:   Types only
`include "ieq_map.svh"
package ieq_pkg;
  typedef logic signed [`IEQ_CODE_W-1:0] ieq_code_t;
  typedef logic [`IEQ_MSG_W-1:0]         ieq_msg_t;
  typedef logic [`IEQ_PTR_W-1:0]         ieq_ptr_t;
  typedef enum logic [1:0] {IEQ_VW_OFF, IEQ_VW_ON} ieq_view_t;
endpackage

// ===== ieq_idle_timer.sv
// Purpose: Front-panel viewer inactivity timer
// Assumes: Activity and open are single-cycle pulses
// Notes:   Fires once when the viewer idles out
`timescale 1ns/10ps
`default_nettype none
`include "ieq_map.svh"
module ieq_idle_timer #(
  parameter longint unsigned IDLE_CYC = `IEQ_IDLE_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic running,
  input  wire logic touch,
  // Timeout pulse
  output logic      expired
);
  // Thirty seconds at full clock rate needs 33 bits
  logic [32:0] cnt_r;
  logic [32:0] cnt_nxt;
  logic        hit;
  assign hit     = running && (cnt_r == 33'(IDLE_CYC - 64'h0000_0000_0000_0001));
  assign cnt_nxt = (!running || touch || hit) ? 33'h0_0000_0000 : cnt_r + 33'h0_0000_0001;
  assign expired = hit && !touch;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 33'h0_0000_0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== ieq_queue.sv
// Purpose: Error queue of an instrument's remote command interface
// Assumes: Parser raises one error pulse at a time; text table outside
// Notes:   RST only powers up; the reset common command has a port but no effect here
//
// How it works
// - Entries leave oldest first
// - Each read removes its entry
// - Indicator lit while queue not empty
// - One beep pulse per generated error
// - Twenty slots; overflow code replaces newest
// - After overflow, drop errors until read
// - Empty read returns zero, no-error text
// - Clear-status and power-up empty queue
// - Reset command leaves queue untouched
// - Viewer exit or idle clears queue
// - One query reads exactly one entry
// - Reply: signed number, comma, quoted text
`timescale 1ns/10ps
`default_nettype none
`include "ieq_map.svh"
module ieq_queue #(
  parameter longint unsigned IDLE_CYC = `IEQ_IDLE_CYC
) (
  // Clock and power-on reset
  input  wire logic              CLK,
  input  wire logic              RST,
  // Error source
  input  wire logic              ERR_VALID,
  input  wire ieq_pkg::ieq_code_t ERR_CODE,
  input  wire ieq_pkg::ieq_msg_t  ERR_MSG,
  // Commands
  input  wire logic              CLS_CMD,
  input  wire logic              RST_CMD,
  input  wire logic              QUERY,
  // Front-panel viewer
  input  wire logic              VIEW_OPEN,
  input  wire logic              VIEW_EXIT,
  input  wire logic              VIEW_ACT,
  // Answer
  output logic                   RESP_VALID,
  output ieq_pkg::ieq_code_t     RESP_CODE,
  output ieq_pkg::ieq_msg_t      RESP_MSG,
  output logic                   RESP_EMPTY,
  // Indicators
  output logic                   ERROR_LAMP,
  output logic                   BEEP,
  output logic [1:0]             VIEW_STATE
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  ieq_pkg::ieq_code_t code_mem [`IEQ_DEPTH];
  ieq_pkg::ieq_msg_t  msg_mem  [`IEQ_DEPTH];
  // Count is one bit wider than the pointers so full and empty differ
  ieq_pkg::ieq_ptr_t  rd_r;
  ieq_pkg::ieq_ptr_t  rd_nxt;
  ieq_pkg::ieq_ptr_t  wr_r;
  ieq_pkg::ieq_ptr_t  wr_nxt;
  ieq_pkg::ieq_ptr_t  last_idx;
  logic [5:0]         cnt_r;
  logic [5:0]         cnt_nxt;
  logic               ovf_r;
  logic               ovf_nxt;
  ieq_pkg::ieq_view_t view_r;
  ieq_pkg::ieq_view_t view_nxt;
  wire                idle_exp;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire full      = (cnt_r == 6'(`IEQ_DEPTH));
  wire empty     = (cnt_r == 6'h00);
  wire view_done = (view_r == ieq_pkg::IEQ_VW_ON) && (VIEW_EXIT || idle_exp);
  wire clr_all   = CLS_CMD || view_done;
  wire do_rd     = QUERY && !empty && !clr_all;
  wire store     = ERR_VALID && !full && !ovf_r && !clr_all;
  // A read in the same cycle wins: that error is dropped unmarked
  wire ovfl_hit  = ERR_VALID && full && !ovf_r && !do_rd && !clr_all;
  function automatic ieq_pkg::ieq_ptr_t ptr_inc(input ieq_pkg::ieq_ptr_t p);
    ptr_inc = (p == 5'(`IEQ_DEPTH - 1)) ? 5'h00 : p + 5'h01;
  endfunction
  assign last_idx = (wr_r == 5'h00) ? 5'(`IEQ_DEPTH - 1) : wr_r - 5'h01;
  assign rd_nxt   = clr_all ? 5'h00 : (do_rd ? ptr_inc(rd_r) : rd_r);
  assign wr_nxt   = clr_all ? 5'h00 : (store ? ptr_inc(wr_r) : wr_r);
  assign cnt_nxt  = clr_all ? 6'h00 : cnt_r + 6'(store) - 6'(do_rd);
  // A read clears the flag; no set can happen in the same cycle as a read
  assign ovf_nxt  = clr_all ? 1'b0 : (ovfl_hit || (ovf_r && !do_rd));
  assign view_nxt = view_done ? ieq_pkg::IEQ_VW_OFF :
                    ((VIEW_OPEN && !empty) ? ieq_pkg::IEQ_VW_ON : view_r);
  // RST_CMD is accepted but deliberately has no path into the queue

  // ----------------------------------------
  // Viewer idle timer
  // ----------------------------------------
  // Any activity restarts the count, so a busy user is never cut off
  ieq_idle_timer #(.IDLE_CYC(IDLE_CYC)) u_idle (
    .clk     (CLK),
    .rst     (RST),
    .running (view_r == ieq_pkg::IEQ_VW_ON),
    .touch   (VIEW_ACT || VIEW_OPEN),
    .expired (idle_exp)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      rd_r   <= 5'h00;
      wr_r   <= 5'h00;
      cnt_r  <= 6'h00;
      ovf_r  <= 1'b0;
      view_r <= ieq_pkg::IEQ_VW_OFF;
    end else begin
      rd_r   <= rd_nxt;
      wr_r   <= wr_nxt;
      cnt_r  <= cnt_nxt;
      ovf_r  <= ovf_nxt;
      view_r <= view_nxt;
    end
  end

  // Slots keep code and text index; no reset needed on data
  always_ff @(posedge CLK) begin
    if (store) begin
      code_mem[wr_r] <= ERR_CODE;
      msg_mem[wr_r]  <= ERR_MSG;
    end else if (ovfl_hit) begin
      code_mem[last_idx] <= `IEQ_CODE_OVFL;
      msg_mem[last_idx]  <= `IEQ_MSG_OVFL;
    end
  end

  // ----------------------------------------
  // Answer and indicators
  // ----------------------------------------
  // Reply holds one cycle, then falls back to the no-error entry
  always_ff @(posedge CLK) begin
    if (RST) begin
      RESP_VALID <= 1'b0;
      RESP_CODE  <= `IEQ_CODE_NONE;
      RESP_MSG   <= `IEQ_MSG_NONE;
      RESP_EMPTY <= 1'b0;
      BEEP       <= 1'b0;
    end else begin
      RESP_VALID <= QUERY;
      RESP_CODE  <= do_rd ? code_mem[rd_r] : `IEQ_CODE_NONE;
      RESP_MSG   <= do_rd ? msg_mem[rd_r] : `IEQ_MSG_NONE;
      RESP_EMPTY <= QUERY && !do_rd;
      BEEP       <= ERR_VALID;
    end
  end
  assign ERROR_LAMP = !empty;
  assign VIEW_STATE = view_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Internal counts are watched too, not only the ports
  a_beep_per_err:  assert property (@(posedge CLK) disable iff (RST) ERR_VALID |=> BEEP)
    else $error("missing beep");
  a_beep_only:     assert property (@(posedge CLK) disable iff (RST) BEEP |-> $past(ERR_VALID))
    else $error("spurious beep");
  a_lamp_state:    assert property (@(posedge CLK) disable iff (RST) store |=> ERROR_LAMP)
    else $error("lamp not lit after store");
  a_lamp_off:      assert property (@(posedge CLK) disable iff (RST)
    (do_rd && !store && cnt_r == 6'h01) |=> !ERROR_LAMP)
    else $error("lamp lit after last read");
  a_empty_reply:   assert property (@(posedge CLK) disable iff (RST)
    (QUERY && empty) |=> (RESP_VALID && RESP_EMPTY && RESP_CODE == `IEQ_CODE_NONE))
    else $error("bad empty reply");
  a_empty_msg:     assert property (@(posedge CLK) disable iff (RST)
    (QUERY && empty) |=> (RESP_MSG == `IEQ_MSG_NONE))
    else $error("bad empty text index");
  a_read_removes:  assert property (@(posedge CLK) disable iff (RST)
    (do_rd && !store) |=> (cnt_r == $past(cnt_r) - 6'h01))
    else $error("read did not remove");
  a_store_adds:    assert property (@(posedge CLK) disable iff (RST)
    (store && !do_rd) |=> (cnt_r == $past(cnt_r) + 6'h01))
    else $error("store did not add");
  a_one_reply:     assert property (@(posedge CLK) disable iff (RST) RESP_VALID |-> $past(QUERY))
    else $error("reply without query");
  a_resp_idle:     assert property (@(posedge CLK) disable iff (RST)
    !QUERY |=> (!RESP_VALID && RESP_CODE == `IEQ_CODE_NONE && RESP_MSG == `IEQ_MSG_NONE))
    else $error("reply held past its cycle");
  a_cap_twenty:    assert property (@(posedge CLK) disable iff (RST) cnt_r <= 6'(`IEQ_DEPTH))
    else $error("depth exceeded");
  a_full_keeps:    assert property (@(posedge CLK) disable iff (RST)
    ovfl_hit |=> (cnt_r == 6'(`IEQ_DEPTH)))
    else $error("overflow changed count");
  a_ovf_code:      assert property (@(posedge CLK) disable iff (RST)
    ovfl_hit |=> (code_mem[$past(last_idx)] == `IEQ_CODE_OVFL))
    else $error("overflow code missing");
  a_ovf_drop:      assert property (@(posedge CLK) disable iff (RST)
    (ovf_r && !do_rd && !clr_all) |=> (cnt_r == $past(cnt_r)))
    else $error("stored after overflow");
  a_ovf_release:   assert property (@(posedge CLK) disable iff (RST) (ovf_r && do_rd) |=> !ovf_r)
    else $error("overflow not released by read");
  a_cls_clears:    assert property (@(posedge CLK) disable iff (RST) CLS_CMD |=> !ERROR_LAMP)
    else $error("clear-status failed");
  a_clear_ptrs:    assert property (@(posedge CLK) disable iff (RST)
    clr_all |=> (rd_r == 5'h00 && wr_r == 5'h00 && !ovf_r))
    else $error("clear left state behind");
  a_rstcmd_keeps:  assert property (@(posedge CLK) disable iff (RST)
    (RST_CMD && !clr_all && !ERR_VALID && !QUERY) |=> (cnt_r == $past(cnt_r)))
    else $error("reset command touched queue");
  a_view_clears:   assert property (@(posedge CLK) disable iff (RST) view_done |=> !ERROR_LAMP)
    else $error("viewer close kept errors");
  a_view_opens:    assert property (@(posedge CLK) disable iff (RST)
    (VIEW_OPEN && !empty && !view_done) |=> (VIEW_STATE == 2'h1))
    else $error("viewer did not open");
  a_view_quiet:    assert property (@(posedge CLK) disable iff (RST) (view_r != ieq_pkg::IEQ_VW_ON) |-> !idle_exp)
    else $error("idle timeout while closed");
  a_order_fifo:    assert property (@(posedge CLK) disable iff (RST)
    do_rd |=> (RESP_CODE == $past(code_mem[rd_r])))
    else $error("order broken");
  // Main scenarios
  c_full:     cover property (@(posedge CLK) disable iff (RST) full);
  c_empty_q:  cover property (@(posedge CLK) disable iff (RST) QUERY && empty);
  c_overflow: cover property (@(posedge CLK) disable iff (RST) ovfl_hit);
  c_view_to:  cover property (@(posedge CLK) disable iff (RST) idle_exp);
  c_drain:    cover property (@(posedge CLK) disable iff (RST) do_rd && cnt_r == 6'h01);
endmodule
`default_nettype wire

// ===== ieq_host_model.sv
// Purpose: Remote host that sends error queries
// Assumes: One reply per query, one cycle later
// Notes:   Reply code latch is spoiled on each query made in a cycle without a reply, so a stale code fails
`timescale 1ns/10ps
`default_nettype none
module ieq_host_model (
  // Clock
  input  wire logic               clk,
  // Query side
  input  wire logic               ask,
  output logic                    query,
  // Reply side
  input  wire logic               rv,
  input  wire ieq_pkg::ieq_code_t rc,
  input  wire ieq_pkg::ieq_msg_t  rm,
  input  wire logic               re,
  output ieq_pkg::ieq_code_t      got_c,
  output ieq_pkg::ieq_msg_t       got_m,
  output logic                    got_e
);
  assign query = ask;
  always_ff @(posedge clk) begin
    if (rv) begin
      got_c <= rc;
      got_m <= rm;
      got_e <= re;
    end else if (query) begin
      got_c <= 16'h5A5A;
    end
  end
endmodule
`default_nettype wire

// ===== ieq_queue_tb_top.sv
// Purpose: Self-checking bench for ieq_queue
// Assumes: Idle timeout shortened to 50 cycles
// Notes:   Table rows first, then hand tests
`timescale 1ns/10ps
`default_nettype none
`include "ieq_map.svh"
module ieq_queue_tb_top;
  // ------
  // Signals
  // ------
  localparam int IDLE = 50;
  // Row: in e,q,r,-; code; msg; out v,empty,lamp,beep; code; msg
  localparam logic [55:0] ROWS [9] = '{56'h8_FF9A_02_3_0000_00, 56'h8_FF99_03_3_0000_00,
    56'h4_0000_00_A_FF9A_02, 56'hC_FF98_04_B_FF99_03, 56'h4_0000_00_8_FF98_04,
    56'h4_0000_00_C_0000_00, 56'hA_FF97_05_3_0000_00, 56'h2_0000_00_2_0000_00,
    56'h4_0000_00_8_FF97_05};
  logic clk = 0, rst = 1, ev = 0, cls = 0, rc = 0, ask = 0, vo = 0, vx = 0, va = 0;
  logic query, rv, re, lamp, beep, ge;
  logic [1:0] vs;
  logic [15:0] code = 16'h0000;
  logic [7:0] msg = 8'h00;
  ieq_pkg::ieq_code_t rcode, gc;
  ieq_pkg::ieq_msg_t rmsg, gm;
  int errors = 0, n_compared = 0, cyc = 0;
  ieq_queue #(.IDLE_CYC(IDLE)) ieq_queue_i (.CLK(clk), .RST(rst), .ERR_VALID(ev), .ERR_CODE(code),
    .ERR_MSG(msg), .CLS_CMD(cls), .RST_CMD(rc), .QUERY(query), .VIEW_OPEN(vo), .VIEW_EXIT(vx),
    .VIEW_ACT(va), .RESP_VALID(rv), .RESP_CODE(rcode), .RESP_MSG(rmsg), .RESP_EMPTY(re),
    .ERROR_LAMP(lamp), .BEEP(beep), .VIEW_STATE(vs));
  ieq_host_model ieq_host_model_i (.clk(clk), .ask(ask), .query(query), .rv(rv), .rc(rcode),
    .rm(rmsg), .re(re), .got_c(gc), .got_m(gm), .got_e(ge));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end
  task automatic chk_b(input logic g, input logic x);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %0t flag got %b exp %b", $time, g, x);
    end
  endtask
  task automatic chk_w(input logic [15:0] g, input logic [15:0] x);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %0t word got %h exp %h", $time, g, x);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic push(input logic [15:0] c);
    code = c;
    msg = 8'h07;
    pulse(ev);
    chk_b(beep, 1'b1);
    @(negedge clk);
    chk_b(beep, 1'b0);
  endtask
  task automatic qry(input logic [15:0] xc, input logic [7:0] xm, input logic xe);
    pulse(ask);
    @(negedge clk);
    chk_w(gc, xc);
    chk_w({8'h00, gm}, {8'h00, xm});
    chk_b(ge, xe);
  endtask
  task automatic results();
    $display("errors %0d n_compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------
  // Tests
  // ------
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk_b(lamp, 1'b0);
    qry(16'h0000, 8'h00, 1'b1);
    $display("reset done");
    foreach (ROWS[i]) begin
      {ev, ask, rc} = ROWS[i][55:53];
      {code, msg} = ROWS[i][51:28];
      @(negedge clk);
      chk_b(rv, ROWS[i][27]);
      chk_b(re, ROWS[i][26]);
      chk_b(lamp, ROWS[i][25]);
      chk_b(beep, ROWS[i][24]);
      chk_w(rcode, ROWS[i][23:8]);
      chk_w({8'h00, rmsg}, {8'h00, ROWS[i][7:0]});
    end
    {ask, rc} = 2'h0;
    $display("rows done");
    for (int k = 1; k <= 22; k++) push(16'(k));
    qry(16'h0001, 8'h07, 1'b0);
    push(16'h004D);
    for (int k = 2; k <= 19; k++) qry(16'(k), 8'h07, 1'b0);
    qry(`IEQ_CODE_OVFL, `IEQ_MSG_OVFL, 1'b0);
    qry(16'h004D, 8'h07, 1'b0);
    qry(16'h0000, 8'h00, 1'b1);
    $display("overflow done");
    push(16'hFF9A);
    push(16'hFF99);
    pulse(cls);
    @(negedge clk);
    chk_b(lamp, 1'b0);
    qry(16'h0000, 8'h00, 1'b1);
    $display("clear done");
    push(16'h0001);
    pulse(vo);
    @(negedge clk);
    chk_w({14'h0000, vs}, 16'h0001);
    pulse(vx);
    repeat (2) @(negedge clk);
    chk_b(lamp, 1'b0);
    chk_w({14'h0000, vs}, 16'h0000);
    push(16'h0002);
    pulse(vo);
    repeat (IDLE / 2) @(negedge clk);
    pulse(va);
    repeat (IDLE / 2 + 5) @(negedge clk);
    chk_b(lamp, 1'b1);
    repeat (IDLE) @(negedge clk);
    chk_b(lamp, 1'b0);
    $display("viewer done");
    push(16'h0003);
    chk_b(lamp, 1'b1);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk_b(lamp, 1'b0);
    qry(16'h0000, 8'h00, 1'b1);
    $display("reset test done");
    results();
  end
endmodule
`default_nettype wire
